/* File: src/hssc_pkg.sv */
package hssc_pkg;
   localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
   localparam logic [6:0] ADDR_SRC_A = 7'h14;
   localparam logic [6:0] ADDR_SRC_B = 7'h15;
   localparam logic [6:0] ADDR_PIN_CFG = 7'h17;
   localparam logic [6:0] ADDR_PWM_ONE = 7'h18;
   localparam int BIT_OV_DIS = 6;
   localparam int BIT_UV_DIS = 5;
   localparam int BIT_REC_EN = 4;
   localparam logic [7:0] SHUTDOWN_MASK = 8'h70;
   localparam logic [7:0] SRC_MASK = 8'h77;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int SRC_LO = 0;
   localparam int SRC_HI = 4;
   localparam int FRAME_BITS = 16;
   localparam int WRITE_BIT = 8;
   localparam logic [7:0] PWM_FULL = 8'hFF;
   localparam logic [7:0] PWM_TOP = 8'hFE;
   localparam int PWM_PRESCALE = 1960;
   localparam int PWM_PRE_W = 11;
   localparam int FAIL_PERIOD = 1000000;
   localparam int FAIL_DIV_20 = 5;
   localparam int FAIL_DIV_10 = 10;
   localparam int FAIL_DIV_5 = 20;
   localparam int FAIL_DIV_2P5 = 40;

   typedef enum logic [2:0] {
      SRC_OFF = 3'h0, SRC_ON = 3'h1, SRC_TMR1 = 3'h2, SRC_TMR2 = 3'h3,
      SRC_PWM1 = 3'h4, SRC_PWM2 = 3'h5
   } hssc_src_e;

   typedef enum logic [1:0] {
      FR_IDLE = 2'b00, FR_SHIFT = 2'b01, FR_DONE = 2'b11
   } hssc_frame_e;

   typedef struct packed {
      logic overvoltage;
      logic undervoltage;
      logic [3:0] overcurrent;
      logic [3:0] overtemp;
   } hssc_fault_s;

   typedef struct packed {
      logic cyclic_timer_one;
      logic cyclic_timer_two;
      logic pwm_two;
   } hssc_gen_s;
endpackage

/* File: src/hssc_pwm.sv */
`timescale 1ns/1ns
module hssc_pwm #(
   parameter int PRESCALE = hssc_pkg::PWM_PRESCALE
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] duty,
   output logic pwm_out
);
   typedef struct packed {
      logic [hssc_pkg::PWM_PRE_W-1:0] pre;
      logic [7:0] phase;
      logic out;
   } hssc_pwm_s;
   hssc_pwm_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      if (st_reg.pre == hssc_pkg::PWM_PRE_W'(PRESCALE - 1)) begin
         st_next.pre = '0;
         st_next.phase = (st_reg.phase == hssc_pkg::PWM_TOP) ?
            8'h00 : st_reg.phase + 8'h01;
      end else begin
         st_next.pre = st_reg.pre + 1'b1;
      end
      st_next.out = (duty == hssc_pkg::PWM_FULL) ? 1'b1 :
                    (st_next.phase < duty);
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) st_reg <= '0;
      else st_reg <= st_next;
   end
   assign pwm_out = st_reg.out;

   chk_pwm_zero_off: assert property (@(posedge core_clk) disable iff
      (!reset_n) (duty == 8'h00) [*2] |-> !pwm_out)
      else $error("pwm on with zero duty");
endmodule // hssc_pwm

/* File: src/hssc_frame.sv */
`timescale 1ns/1ns
module hssc_frame (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic frame_sel_n,
   input wire logic frame_sck,
   input wire logic frame_sdi,
   output logic frame_done,
   output logic [15:0] frame_word
);
   typedef struct packed {
      hssc_pkg::hssc_frame_e state;
      logic sck_d;
      logic [4:0] count;
      logic [15:0] shift;
      logic done;
   } hssc_frame_s;
   hssc_frame_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.sck_d = frame_sck;
      st_next.done = 1'b0;
      case (st_reg.state)
         hssc_pkg::FR_IDLE: begin
            st_next.count = '0;
            if (!frame_sel_n) st_next.state = hssc_pkg::FR_SHIFT;
         end
         hssc_pkg::FR_SHIFT: begin
            if (frame_sck && !st_reg.sck_d) begin
               st_next.shift = {st_reg.shift[14:0], frame_sdi};
               st_next.count = st_reg.count + 5'd1;
            end
            if (frame_sel_n) begin
               st_next.state = hssc_pkg::FR_DONE;
               st_next.done = (st_reg.count == 5'(hssc_pkg::FRAME_BITS));
            end
         end
         hssc_pkg::FR_DONE: st_next.state = hssc_pkg::FR_IDLE;
         default: st_next.state = hssc_pkg::FR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) st_reg <= '0;
      else st_reg <= st_next;
   end
   assign frame_done = st_reg.done;
   assign frame_word = st_reg.shift;
endmodule // hssc_frame

/* File: src/hssc_top.sv */
`timescale 1ns/1ns
// Behaviour
// - Shutdown bit 6 set suppresses overvoltage switch-off.
// - Shutdown bit 5 set suppresses undervoltage switch-off.
// - Shutdown bit 4 restores prior switch state after supply fault.
// - Reserved bits always read zero.
// - Three-bit source code selects off, on, timers or PWMs.
// - Source register A holds switches one and two.
// - Source register B holds switches three and four.
// - Overcurrent or overtemperature clears that switch source.
// - Pin config bits 7:6 choose fail output duty.
// - Pin fields select fail output, off, wake, low or high drive.
// - PWM one duty: zero off, all ones on, else value/255.
// - Power-on or soft reset zeroes all five registers.
// - Restart clears both source registers.
// - Restart keeps pin config and PWM one duty.
// - Restart keeps shutdown bits 6:4 and clears others.
// - Access is one 16-bit frame: address, mode, data.
module hssc_top #(
   parameter int PWM_PRESCALE = hssc_pkg::PWM_PRESCALE,
   parameter int FAIL_PERIOD = hssc_pkg::FAIL_PERIOD
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic soft_reset,
   input wire logic restart_entry,
   input wire logic frame_sel_n,
   input wire logic frame_sck,
   input wire logic frame_sdi,
   input wire hssc_pkg::hssc_fault_s fault,
   input wire hssc_pkg::hssc_gen_s gen,
   input wire logic fail_active,
   output logic [7:0] read_data,
   output logic read_valid,
   output logic [3:0] switch_on,
   output logic [1:0] pin_high_drive,
   output logic [1:0] pin_low_drive,
   output logic [1:0] pin_wake_enable,
   output logic [1:0] pin_fail_active,
   output logic [7:0] pwm_one_duty
);
   typedef struct packed {
      logic [7:0] shutdown;
      logic [7:0] src_a;
      logic [7:0] src_b;
      logic [7:0] pin_cfg;
      logic [7:0] pwm_duty;
      logic [15:0] saved_src;
      logic supply_off_d;
      logic [7:0] rdata;
      logic rvalid;
      logic [3:0] sw;
      logic [1:0] hi;
      logic [1:0] lo;
      logic [1:0] wake;
      logic [1:0] fo;
      logic [19:0] fail_cnt;
   } hssc_top_s;
   hssc_top_s st_reg, st_next;

   logic frame_done;
   logic [15:0] frame_word;
   logic pwm_one_out;
   logic [11:0] src_all;
   logic [3:0] gen_level;
   logic [3:0] hw_clear;
   logic ov_off;
   logic uv_off;
   logic supply_off;
   logic [19:0] fail_on_len;
   logic fail_wave;

   hssc_frame u_frame (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .frame_sel_n(frame_sel_n),
      .frame_sck(frame_sck),
      .frame_sdi(frame_sdi),
      .frame_done(frame_done),
      .frame_word(frame_word)
   );

   hssc_pwm #(.PRESCALE(PWM_PRESCALE)) u_pwm_one (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .duty(st_reg.pwm_duty),
      .pwm_out(pwm_one_out)
   );

   function automatic logic src_level(input logic [2:0] code,
      input hssc_pkg::hssc_gen_s g, input logic p1);
      case (code)
         hssc_pkg::SRC_ON: src_level = 1'b1;
         hssc_pkg::SRC_TMR1: src_level = g.cyclic_timer_one;
         hssc_pkg::SRC_TMR2: src_level = g.cyclic_timer_two;
         hssc_pkg::SRC_PWM1: src_level = p1;
         hssc_pkg::SRC_PWM2: src_level = g.pwm_two;
         default: src_level = 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] pin_mode(input logic [2:0] code);
      pin_mode = code[1:0];
   endfunction

   assign src_all = {st_reg.src_b[6:4], st_reg.src_b[2:0],
                     st_reg.src_a[6:4], st_reg.src_a[2:0]};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sw
         assign gen_level[gi] = src_level(src_all[gi*3 +: 3], gen,
                                          pwm_one_out);
         assign hw_clear[gi] = fault.overcurrent[gi] | fault.overtemp[gi];
      end
   endgenerate

   assign ov_off = fault.overvoltage &
                   !st_reg.shutdown[hssc_pkg::BIT_OV_DIS];
   assign uv_off = fault.undervoltage &
                   !st_reg.shutdown[hssc_pkg::BIT_UV_DIS];
   assign supply_off = ov_off | uv_off;

   always_comb begin
      case (st_reg.pin_cfg[7:6])
         2'b00: fail_on_len = 20'(FAIL_PERIOD / hssc_pkg::FAIL_DIV_20);
         2'b01: fail_on_len = 20'(FAIL_PERIOD / hssc_pkg::FAIL_DIV_10);
         2'b10: fail_on_len = 20'(FAIL_PERIOD / hssc_pkg::FAIL_DIV_5);
         default: fail_on_len = 20'(FAIL_PERIOD / hssc_pkg::FAIL_DIV_2P5);
      endcase
   end
   assign fail_wave = fail_active & (st_reg.fail_cnt < fail_on_len);

   always_comb begin
      logic [6:0] addr;
      logic wr;
      logic [7:0] wdata;
      logic [15:0] src_next;
      addr = frame_word[15:9];
      wr = frame_word[hssc_pkg::WRITE_BIT];
      wdata = frame_word[7:0];
      src_next = '0;
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.supply_off_d = supply_off;
      st_next.fail_cnt = (st_reg.fail_cnt == 20'(FAIL_PERIOD - 1)) ?
                         '0 : st_reg.fail_cnt + 20'd1;
      if (frame_done) begin
         if (wr) begin
            case (addr)
               hssc_pkg::ADDR_SHUTDOWN:
                  st_next.shutdown = wdata & hssc_pkg::SHUTDOWN_MASK;
               hssc_pkg::ADDR_SRC_A:
                  st_next.src_a = wdata & hssc_pkg::SRC_MASK;
               hssc_pkg::ADDR_SRC_B:
                  st_next.src_b = wdata & hssc_pkg::SRC_MASK;
               hssc_pkg::ADDR_PIN_CFG: st_next.pin_cfg = wdata;
               hssc_pkg::ADDR_PWM_ONE: st_next.pwm_duty = wdata;
               default: ;
            endcase
         end
         case (addr)
            hssc_pkg::ADDR_SHUTDOWN: st_next.rdata = st_next.shutdown;
            hssc_pkg::ADDR_SRC_A: st_next.rdata = st_next.src_a;
            hssc_pkg::ADDR_SRC_B: st_next.rdata = st_next.src_b;
            hssc_pkg::ADDR_PIN_CFG: st_next.rdata = st_next.pin_cfg;
            hssc_pkg::ADDR_PWM_ONE: st_next.rdata = st_next.pwm_duty;
            default: st_next.rdata = hssc_pkg::RESET_VALUE;
         endcase
         st_next.rvalid = 1'b1;
      end
      if (supply_off && !st_reg.supply_off_d)
         st_next.saved_src = {st_next.src_b, st_next.src_a};
      if (supply_off) begin
         st_next.src_a = hssc_pkg::RESET_VALUE;
         st_next.src_b = hssc_pkg::RESET_VALUE;
      end
      if (!supply_off && st_reg.supply_off_d &&
          st_reg.shutdown[hssc_pkg::BIT_REC_EN]) begin
         st_next.src_a = st_reg.saved_src[7:0];
         st_next.src_b = st_reg.saved_src[15:8];
      end
      for (int i = 0; i < 4; i++) begin
         if (hw_clear[i]) begin
            src_next = {st_next.src_b, st_next.src_a};
            src_next[(i/2)*8 + (i%2)*hssc_pkg::SRC_HI +: 3] = 3'h0;
            st_next.src_a = src_next[7:0];
            st_next.src_b = src_next[15:8];
         end
      end
      if (restart_entry) begin
         st_next.src_a = hssc_pkg::RESET_VALUE;
         st_next.src_b = hssc_pkg::RESET_VALUE;
         st_next.shutdown = st_reg.shutdown & hssc_pkg::SHUTDOWN_MASK;
         st_next.pin_cfg = st_reg.pin_cfg;
         st_next.pwm_duty = st_reg.pwm_duty;
      end
      st_next.sw = supply_off ? 4'h0 : gen_level;
      for (int p = 0; p < 2; p++) begin
         logic [2:0] c;
         c = st_reg.pin_cfg[p*3 +: 3];
         st_next.hi[p] = (c == 3'h7);
         st_next.lo[p] = (c == 3'h6);
         st_next.wake[p] = (c == 3'h5);
         st_next.fo[p] = !c[2] & fail_wave & (pin_mode(c) <= 2'h3);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n || soft_reset) st_reg <= '0;
      else st_reg <= st_next;
   end

   assign read_data = st_reg.rdata;
   assign read_valid = st_reg.rvalid;
   assign switch_on = st_reg.sw;
   assign pin_high_drive = st_reg.hi;
   assign pin_low_drive = st_reg.lo;
   assign pin_wake_enable = st_reg.wake;
   assign pin_fail_active = st_reg.fo;
   assign pwm_one_duty = st_reg.pwm_duty;

   chk_reserved_zero: assert property (@(posedge core_clk) disable iff
      (!reset_n) st_reg.shutdown[7] == 1'b0 && st_reg.shutdown[3:0] == 4'h0
      && st_reg.src_a[7] == 1'b0 && st_reg.src_b[3] == 1'b0)
      else $error("reserved bit set");
   chk_ov_shutdown: assert property (@(posedge core_clk) disable iff
      (!reset_n) fault.overvoltage && !st_reg.shutdown[6] |=> switch_on == 0)
      else $error("switch on in overvoltage");
   chk_uv_shutdown: assert property (@(posedge core_clk) disable iff
      (!reset_n) fault.undervoltage && !st_reg.shutdown[5] |=> switch_on == 0)
      else $error("switch on in undervoltage");
   chk_fault_clear: assert property (@(posedge core_clk) disable iff
      (!reset_n || soft_reset) fault.overcurrent[0] |=> st_reg.src_a[2:0] == 0)
      else $error("source not cleared");
   chk_restart_clear: assert property (@(posedge core_clk) disable iff
      (!reset_n || soft_reset) restart_entry |=> st_reg.src_a == 0 &&
      st_reg.src_b == 0 && st_reg.pwm_duty == $past(st_reg.pwm_duty))
      else $error("restart mishandled");
   chk_restart_shut: assert property (@(posedge core_clk) disable iff
      (!reset_n || soft_reset) restart_entry |=>
      st_reg.shutdown == ($past(st_reg.shutdown) & 8'h70))
      else $error("restart shutdown wrong");
   chk_pin_keep: assert property (@(posedge core_clk) disable iff
      (!reset_n || soft_reset) restart_entry |=>
      st_reg.pin_cfg == $past(st_reg.pin_cfg))
      else $error("pin config lost");
   chk_soft_reset: assert property (@(posedge core_clk) disable iff
      (!reset_n) soft_reset |=> st_reg.shutdown == 0 && st_reg.pin_cfg == 0
      && pwm_one_duty == 0) else $error("soft reset failed");
   chk_on_source: assert property (@(posedge core_clk) disable iff
      (!reset_n) st_reg.src_a[2:0] == 3'h1 && !supply_off |=> switch_on[0])
      else $error("on source not driven");
   chk_reserved_code: assert property (@(posedge core_clk) disable iff
      (!reset_n) st_reg.src_a[2:1] == 2'b11 |=> !switch_on[0])
      else $error("reserved code drives");
   cov_write_frame: cover property (@(posedge core_clk) frame_done &&
      frame_word[8]);
   cov_recover: cover property (@(posedge core_clk) $fell(supply_off) &&
      st_reg.shutdown[4]);
   cov_pwm_switch: cover property (@(posedge core_clk) switch_on[0] &&
      st_reg.src_a[2:0] == 3'h4);
endmodule // hssc_top

/* File: verif/hssc_load_model.sv */
`timescale 1ns/1ns
// Loads on the four switches: a shorted or overheated load reports a fault
// only while its switch actually drives it, as a real load would.
module hssc_load_model (
   input wire logic [3:0] switch_on,
   input wire logic [3:0] short_cmd,
   input wire logic [3:0] hot_cmd,
   output logic [3:0] overcurrent,
   output logic [3:0] overtemp
);
   assign overcurrent = switch_on & short_cmd;
   assign overtemp = switch_on & hot_cmd;
endmodule // hssc_load_model

/* File: verif/hssc_top_test.sv */
`timescale 1ns/1ns
module hssc_top_test;
   logic core_clk;
   logic reset_n;
   logic soft_reset;
   logic restart_entry;
   logic frame_sel_n;
   logic frame_sck;
   logic frame_sdi;
   logic ov;
   logic uv;
   hssc_pkg::hssc_fault_s fault;
   hssc_pkg::hssc_gen_s gen;
   logic [3:0] short_cmd;
   logic [3:0] hot_cmd;
   logic [3:0] overcurrent;
   logic [3:0] overtemp;
   logic [7:0] read_data;
   logic read_valid;
   logic [3:0] switch_on;
   logic [1:0] pin_high_drive;
   logic [1:0] pin_low_drive;
   logic [1:0] pin_wake_enable;
   logic [1:0] pin_fail_active;
   logic [7:0] pwm_one_duty;
   logic [7:0] q;
   logic fail_act;
   logic [6:0] ad [5];
   int err_total;
   int tests_run;

   assign fault = {ov, uv, overcurrent, overtemp};

   hssc_top #(.PWM_PRESCALE(2), .FAIL_PERIOD(40)) i_hssc_top (
      .core_clk(core_clk), .reset_n(reset_n), .soft_reset(soft_reset),
      .restart_entry(restart_entry), .frame_sel_n(frame_sel_n),
      .frame_sck(frame_sck), .frame_sdi(frame_sdi), .fault(fault),
      .gen(gen), .fail_active(fail_act), .read_data(read_data),
      .read_valid(read_valid), .switch_on(switch_on),
      .pin_high_drive(pin_high_drive), .pin_low_drive(pin_low_drive),
      .pin_wake_enable(pin_wake_enable),
      .pin_fail_active(pin_fail_active), .pwm_one_duty(pwm_one_duty)
   );

   hssc_load_model i_hssc_load_model (
      .switch_on(switch_on), .short_cmd(short_cmd), .hot_cmd(hot_cmd),
      .overcurrent(overcurrent), .overtemp(overtemp)
   );

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string s, input logic [7:0] e,
                        input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask

   // One whole frame: address, access bit, data; answer lands in q.
   task automatic xfer(input logic [6:0] a, input logic w,
                       input logic [7:0] d);
      logic [15:0] word;
      int n;
      word = {a, w, d};
      n = 0;
      @(negedge core_clk);
      frame_sel_n = 1'h0;
      for (int i = 15; i >= 0; i--) begin
         @(negedge core_clk);
         frame_sck = 1'h0;
         frame_sdi = word[i];
         @(negedge core_clk);
         frame_sck = 1'h1;
      end
      @(negedge core_clk);
      frame_sck = 1'h0;
      frame_sdi = ~frame_sdi;
      @(negedge core_clk);
      frame_sel_n = 1'h1;
      while (read_valid !== 1'h1 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 8) begin
         err_total++;
         $display("wrong value read_valid expected 1 seen 0");
         complete_run();
      end
      q = read_data;
      repeat (2) @(negedge core_clk);
   endtask

   task automatic rchk(input string s, input logic [6:0] a,
                       input logic [7:0] e);
      xfer(a, 1'h0, 8'h00);
      check(s, e, q);
   endtask

   task automatic swchk(input logic [3:0] e);
      repeat (3) @(negedge core_clk);
      check("switch_on", {4'h0, e}, {4'h0, switch_on});
   endtask

   // Counts fail output cycles over one whole fail period of 40 cycles.
   task automatic fail_chk(input int e);
      int on;
      on = 0;
      repeat (40) begin
         @(negedge core_clk);
         on += (pin_fail_active[0] === 1'h1);
      end
      check("fail_on_cycles", 8'(e), 8'(on));
   endtask

   task automatic duty_run(input logic [7:0] d, input int lo, input int hi);
      int on;
      on = 0;
      xfer(ad[4], 1'h1, d);
      repeat (1100) @(negedge core_clk);
      repeat (5100) begin
         @(negedge core_clk);
         on += (switch_on[0] === 1'h1);
      end
      tests_run++;
      if (on < lo || on > hi) begin
         err_total++;
         $display("wrong value on_cycles expected %0d seen %0d", lo, on);
      end
   endtask

   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      repeat (95000) @(posedge core_clk);
      err_total++;
      $display("wrong value run_length expected done seen timeout");
      complete_run();
   end

   initial begin
      reset_n = 1'h0;
      soft_reset = 1'h0;
      restart_entry = 1'h0;
      frame_sel_n = 1'h1;
      frame_sck = 1'h0;
      frame_sdi = 1'h0;
      ov = 1'h0;
      uv = 1'h0;
      gen = 3'h0;
      fail_act = 1'h0;
      short_cmd = 4'h0;
      hot_cmd = 4'h0;
      err_total = 0;
      tests_run = 0;
      ad = '{hssc_pkg::ADDR_SHUTDOWN, hssc_pkg::ADDR_SRC_A,
             hssc_pkg::ADDR_SRC_B, hssc_pkg::ADDR_PIN_CFG,
             hssc_pkg::ADDR_PWM_ONE};
      repeat (8) @(negedge core_clk);
      reset_n = 1'h1;
      for (int i = 0; i < 5; i++) begin
         rchk("reset value", ad[i], 8'h00);
      end
      $display("end of reset test");
      xfer(ad[0], 1'h1, 8'hFF);
      check("shutdown", 8'h70, q);
      xfer(ad[1], 1'h1, 8'h88);
      check("source a", 8'h00, q);
      xfer(7'h11, 1'h1, 8'hFF);
      rchk("unmapped", 7'h11, 8'h00);
      xfer(ad[3], 1'h1, 8'h37);
      check("pin drive", 8'h21, {2'h0, pin_low_drive, 2'h0, pin_high_drive});
      xfer(ad[3], 1'h1, 8'h2C);
      check("pin wake", 8'h20, {2'h0, pin_wake_enable, 2'h0, pin_high_drive});
      xfer(ad[3], 1'h1, 8'hC0);
      check("pin config", 8'hC0, q);
      fail_act = 1'h1;
      fail_chk(1);
      xfer(ad[3], 1'h1, 8'h00);
      fail_chk(8);
      fail_act = 1'h0;
      $display("end of register test");
      xfer(ad[0], 1'h1, 8'h00);
      xfer(ad[1], 1'h1, 8'h10);
      swchk(4'h2);
      xfer(ad[2], 1'h1, 8'h01);
      swchk(4'h6);
      xfer(ad[1], 1'h1, 8'h32);
      xfer(ad[2], 1'h1, 8'h65);
      gen = 3'h5;
      swchk(4'h5);
      gen = 3'h2;
      swchk(4'h2);
      xfer(ad[2], 1'h1, 8'h07);
      gen = 3'h7;
      swchk(4'h3);
      xfer(ad[1], 1'h1, 8'h07);
      swchk(4'h0);
      gen = 3'h0;
      $display("end of source test");
      xfer(ad[1], 1'h1, 8'h11);
      xfer(ad[2], 1'h1, 8'h00);
      short_cmd = 4'h1;
      swchk(4'h2);
      short_cmd = 4'h0;
      rchk("source a", ad[1], 8'h10);
      hot_cmd = 4'h2;
      swchk(4'h0);
      hot_cmd = 4'h0;
      rchk("source a", ad[1], 8'h00);
      $display("end of load fault test");
      xfer(ad[1], 1'h1, 8'h01);
      ov = 1'h1;
      swchk(4'h0);
      ov = 1'h0;
      swchk(4'h0);
      xfer(ad[0], 1'h1, 8'h40);
      xfer(ad[1], 1'h1, 8'h01);
      ov = 1'h1;
      swchk(4'h1);
      uv = 1'h1;
      swchk(4'h0);
      ov = 1'h0;
      uv = 1'h0;
      xfer(ad[0], 1'h1, 8'h30);
      xfer(ad[1], 1'h1, 8'h01);
      uv = 1'h1;
      swchk(4'h1);
      uv = 1'h0;
      xfer(ad[0], 1'h1, 8'h10);
      ov = 1'h1;
      swchk(4'h0);
      ov = 1'h0;
      swchk(4'h1);
      $display("end of supply test");
      xfer(ad[0], 1'h1, 8'hF0);
      xfer(ad[2], 1'h1, 8'h11);
      xfer(ad[3], 1'h1, 8'h37);
      xfer(ad[4], 1'h1, 8'h5A);
      restart_entry = 1'h1;
      @(negedge core_clk);
      restart_entry = 1'h0;
      swchk(4'h0);
      check("duty out", 8'h5A, pwm_one_duty);
      rchk("restart", ad[0], 8'h70);
      rchk("restart", ad[1], 8'h00);
      rchk("restart", ad[2], 8'h00);
      rchk("restart", ad[3], 8'h37);
      rchk("restart", ad[4], 8'h5A);
      soft_reset = 1'h1;
      @(negedge core_clk);
      soft_reset = 1'h0;
      for (int i = 0; i < 5; i++) begin
         rchk("soft reset", ad[i], 8'h00);
      end
      $display("end of restart test");
      xfer(ad[1], 1'h1, 8'h04);
      duty_run(8'h00, 0, 0);
      duty_run(8'hFF, 5100, 5100);
      duty_run(8'h80, 2440, 2680);
      $display("end of duty test");
      complete_run();
   end
endmodule // hssc_top_test
